// ---- logic/floppy_regs_pkg.sv ----
package floppy_regs_pkg;
  // Wishbone geometry and register indices
  localparam int ADR_W = 12;
  localparam int DAT_W = 32;
  localparam logic [9:0] DOC_IDX = 10'h3F2;
  localparam logic [9:0] TDA_IDX = 10'h3F3;
  localparam logic [9:0] DRS_IDX = 10'h3F4;
  localparam logic [9:0] DATA_IDX = 10'h3F5;
  localparam logic [9:0] CCR_IDX = 10'h3F7;
  localparam logic [9:0] CFG_IDX = 10'h3F8;
  localparam logic [9:0] STAT_IDX = 10'h3F9;
  // Output control register fields
  localparam int DOC_NRST = 2;
  localparam int DOC_DMA = 3;
  localparam int DOC_MOT0 = 4;
  localparam int DOC_MOT1 = 5;
  localparam logic [7:0] DOC_RESET = 8'h00;
  // Data rate select fields
  localparam int DRS_PWR = 6;
  localparam int DRS_SRST = 7;
  localparam logic [7:0] DRS_RESET = 8'h02;
  localparam logic [7:0] DRS_WMASK = 8'hDF;
  // Configuration register fields
  localparam int CFG_MODE = 0;
  localparam int CFG_SWAP = 2;
  localparam int CFG_ENH2 = 3;
  localparam int CFG_BOOT = 4;
  localparam int CFG_TYPE = 8;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Status register fields
  localparam int STAT_RST = 0;
  localparam int STAT_PWR = 1;
  localparam int STAT_DMA = 2;
  localparam int STAT_RATE = 4;
  localparam int STAT_SHIFT = 8;
  // Software reset stretch
  localparam int SRST_MIN_NS = 100;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SRST_CYC_INT = (SRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = $clog2(SRST_CYC_INT + 1);
  localparam logic [CNT_W-1:0] SRST_CYCLES = CNT_W'(SRST_CYC_INT);

  typedef enum logic [1:0] {
    MODE_BASE = 2'b00,
    MODE_LEGACY = 2'b01,
    MODE_ALT = 2'b10,
    MODE_SPARE = 2'b11
  } compat_mode_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic unit_select_out1_n;
    logic unit_select_out0_n;
    logic spindle_out1_n;
    logic spindle_out0_n;
  } drive_pins_type;
endpackage

// ---- logic/floppy_ctl_output_rate_regs.sv ----
`timescale 1ns/1ps
// Contract
// - Output control bits 1:0 are a binary drive number; one drive at most.
// - Writing reset bit 2 low holds controller in reset until written high.
// - Software reset leaves rate register, config control and other bits alone.
// - Reset needs at least 100ns; back-to-back low/high writes are valid.
// - Base and legacy modes: bit 3 gates DMA and interrupts; zero after reset.
// - Alternate status mode keeps DMA/interrupts on; bit 3 cleared by reset.
// - Bits 4 and 5 drive motor-on outputs for drives 0 and 1.
// - Bits 6 and 7 drive no output; drives 2 and 3 motors unsupported.
// - Output control register writable any time, resets to zero.
// - Normal order: selected drive with its motor bit pulls its select low.
// - Swapped order: drive 0 uses select 1, drive 1 select 0, motors swapped.
// - Tape select bits: 00 none, 01/10/11 drives 1-3; drive 0 never.
// - Tape assignment register survives a software reset.
// - Normal floppy mode: tape register holds two bits, upper bits read zero.
// - Enhanced mode 2: tape register returns type id 5:4, boot drive 3:2.
// - Type id is the drive_type_config pair picked by current drive select.
// - Rate register: self-reset 7, power-down 6, zero 5, shift 4:2, rate 1:0.
// - Active rate is the latest write to rate register or config control.
// - Hardware reset loads 02H into rate register; software reset keeps it.
// - Self-reset bit acts as output control reset but clears itself.
// - Power-down bit stops controller; exit on soft reset or data/status access.
module floppy_ctl_output_rate_regs
  import floppy_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Wishbone slave
  input wire wb_req_type wb_req,
  output wire logic wb_ack,
  output wire logic [DAT_W-1:0] wb_dat_o,
  // Drive cable outputs
  output wire drive_pins_type drive_pins,
  // Controller side levels
  output wire logic fdc_reset,
  output wire logic dma_irq_gate,
  output wire logic power_down,
  output wire logic [1:0] rate_code,
  output wire logic [2:0] write_shift_code
);

  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] rdata;
    logic [7:0] digital_output_control;
    logic [1:0] tape_drive_assign;
    logic [7:0] dsr;
    logic [15:0] cfg;
    logic [1:0] rate;
    logic pwr;
    logic [CNT_W-1:0] cnt;
    logic fdc_rst;
    logic dma_en;
    drive_pins_type pins;
  } state_type;

  state_type st_reg;
  state_type st_next;

  // Select and motor decode for two physical drives
  function automatic drive_pins_type drive_decode(input logic [7:0] digital_output_control, input logic swap);
    drive_pins_type p;
    logic pick0;
    logic pick1;
    pick0 = (digital_output_control[1:0] == 2'b00) && digital_output_control[DOC_MOT0];
    pick1 = (digital_output_control[1:0] == 2'b01) && digital_output_control[DOC_MOT1];
    if (swap) begin
      p.unit_select_out1_n = !pick0;
      p.unit_select_out0_n = !pick1;
      p.spindle_out1_n = !digital_output_control[DOC_MOT0];
      p.spindle_out0_n = !digital_output_control[DOC_MOT1];
    end else begin
      p.unit_select_out0_n = !pick0;
      p.unit_select_out1_n = !pick1;
      p.spindle_out0_n = !digital_output_control[DOC_MOT0];
      p.spindle_out1_n = !digital_output_control[DOC_MOT1];
    end
    // Bits 6 and 7 reach no pin
    return p;
  endfunction

  // Tape register read value for the current floppy mode
  function automatic logic [7:0] tape_read(input logic [1:0] tape_drive_assign, input logic [15:0] cfg,
                                           input logic [1:0] drive);
    logic [7:0] v;
    logic [7:0] types;
    v = '0;
    types = cfg[CFG_TYPE +: 8];
    v[1:0] = tape_drive_assign;
    if (cfg[CFG_ENH2]) begin
      v[5:4] = types[{drive, 1'b0} +: 2];
      v[3:2] = cfg[CFG_BOOT +: 2];
    end
    return v;
  endfunction

  logic req;
  logic take;
  logic [9:0] idx;
  logic wr0;
  logic wr1;
  compat_mode_type mode;

  // Bus decode
  assign req = wb_req.cyc && wb_req.stb;
  assign take = req && st_reg.ack;
  assign idx = wb_req.adr[ADR_W-1:2];
  assign wr0 = take && wb_req.we && wb_req.sel[0];
  assign wr1 = take && wb_req.we && wb_req.sel[1];
  assign mode = compat_mode_type'(st_reg.cfg[CFG_MODE +: 2]);

  // Next state of the whole block
  always_comb begin
    logic [DAT_W-1:0] rd;
    logic wake;
    rd = '0;
    wake = 1'b0;
    st_next = st_reg;
    // Single wait state, ack drops the cycle after
    st_next.ack = req && !st_reg.ack;
    // Read data captured as ack rises
    case (idx)
      DOC_IDX: rd = DAT_W'(st_reg.digital_output_control);
      TDA_IDX: rd = DAT_W'(tape_read(st_reg.tape_drive_assign, st_reg.cfg, st_reg.digital_output_control[1:0]));
      CFG_IDX: rd = DAT_W'(st_reg.cfg);
      STAT_IDX: begin
        rd[STAT_RST] = st_reg.fdc_rst;
        rd[STAT_PWR] = st_reg.pwr;
        rd[STAT_DMA] = st_reg.dma_en;
        rd[STAT_RATE +: 2] = st_reg.rate;
        rd[STAT_SHIFT +: 3] = st_reg.dsr[4:2];
      end
      default: rd = '0;
    endcase
    if (req && !st_reg.ack) begin
      st_next.rdata = rd;
    end
    // Reset stretch counts down to zero
    if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - CNT_W'(1);
    end
    // Self-reset bit clears as its stretch ends
    if (st_reg.cnt == CNT_W'(1)) begin
      st_next.dsr[DRS_SRST] = 1'b0;
    end
    // Register writes take effect on the ack edge
    if (wr0) begin
      unique case (idx)
        DOC_IDX: begin
          st_next.digital_output_control = wb_req.dat[7:0];
          if (!wb_req.dat[DOC_NRST]) begin
            st_next.cnt = SRST_CYCLES;
          end
        end
        TDA_IDX: st_next.tape_drive_assign = wb_req.dat[1:0];
        DRS_IDX: begin
          st_next.dsr = wb_req.dat[7:0] & DRS_WMASK;
          st_next.rate = wb_req.dat[1:0];
          if (wb_req.dat[DRS_PWR]) begin
            st_next.pwr = 1'b1;
          end
          if (wb_req.dat[DRS_SRST]) begin
            st_next.cnt = SRST_CYCLES;
          end
        end
        CCR_IDX: st_next.rate = wb_req.dat[1:0];
        CFG_IDX: st_next.cfg[7:0] = wb_req.dat[7:0];
        default: st_next.cfg = st_reg.cfg;
      endcase
    end
    if (wr1 && idx == CFG_IDX) begin
      st_next.cfg[15:8] = wb_req.dat[15:8];
    end
    // Status read or data access ends power-down
    wake = take && ((idx == DATA_IDX) || (idx == DRS_IDX && !wb_req.we));
    if (wake || st_reg.fdc_rst) begin
      st_next.pwr = 1'b0;
    end
    // Controller reset level, other bits untouched
    st_next.fdc_rst = !st_next.digital_output_control[DOC_NRST] || (st_next.cnt != '0);
    // DMA and interrupt gate per compatibility mode
    unique case (mode)
      MODE_ALT: st_next.dma_en = 1'b1;
      MODE_BASE, MODE_LEGACY, MODE_SPARE: st_next.dma_en = st_next.digital_output_control[DOC_DMA];
    endcase
    // Cable outputs are registered in the same cycle as the register
    st_next.pins = drive_decode(st_next.digital_output_control, st_next.cfg[CFG_SWAP]);
  end

  // State register with hardware reset values
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.digital_output_control <= DOC_RESET;
      st_reg.dsr <= DRS_RESET;
      st_reg.rate <= DRS_RESET[1:0];
      st_reg.cfg <= CFG_RESET;
      st_reg.fdc_rst <= 1'b1;
      st_reg.pins <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign wb_ack = st_reg.ack;
  assign wb_dat_o = st_reg.rdata;
  assign drive_pins = st_reg.pins;
  assign fdc_reset = st_reg.fdc_rst;
  assign dma_irq_gate = st_reg.dma_en;
  assign power_down = st_reg.pwr;
  assign rate_code = st_reg.rate;
  assign write_shift_code = st_reg.dsr[4:2];

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence wr_s(logic [9:0] at);
    take && wb_req.we && wb_req.sel[0] && idx == at;
  endsequence

  sequence rd_s(logic [9:0] at);
    take && !wb_req.we && idx == at;
  endsequence

  ack_pulse_a: assert property (wb_ack |=> !wb_ack)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (req && !wb_ack |=> wb_ack)
    else $error("ack not given one cycle after request");
  one_select_a: assert property (!(!drive_pins.unit_select_out0_n && !drive_pins.unit_select_out1_n))
    else $error("both drive selects active");
  normal_pick_a: assert property (
    !st_reg.cfg[CFG_SWAP] && st_reg.digital_output_control[1:0] == 2'b00 && st_reg.digital_output_control[DOC_MOT0] && !wr0
    |=> !drive_pins.unit_select_out0_n && drive_pins.unit_select_out1_n)
    else $error("normal order drive 0 select wrong");
  swap_pick_a: assert property (
    st_reg.cfg[CFG_SWAP] && st_reg.digital_output_control[1:0] == 2'b01 && st_reg.digital_output_control[DOC_MOT1] && !wr0
    |=> !drive_pins.unit_select_out0_n && drive_pins.spindle_out1_n == !$past(st_reg.digital_output_control[DOC_MOT0]))
    else $error("swapped order decode wrong");
  motor_map_a: assert property (!st_reg.cfg[CFG_SWAP] && !wr0 |=>
    drive_pins.spindle_out0_n == !$past(st_reg.digital_output_control[DOC_MOT0]) &&
    drive_pins.spindle_out1_n == !$past(st_reg.digital_output_control[DOC_MOT1]))
    else $error("motor output not inverse of bit");
  reset_hold_a: assert property (wr_s(DOC_IDX) ##0 !wb_req.dat[DOC_NRST]
    |=> fdc_reset [*8])
    else $error("software reset not held");
  reset_end_a: assert property ($fell(fdc_reset) |-> st_reg.digital_output_control[DOC_NRST] && st_reg.cnt == '0)
    else $error("software reset released early");
  keep_regs_a: assert property (fdc_reset && !wr0 |=>
    $stable(st_reg.digital_output_control) && $stable(st_reg.tape_drive_assign) && $stable(st_reg.rate) && $stable(st_reg.dsr[6:0]))
    else $error("register changed by software reset");
  rate_recent_a: assert property ((wr_s(DRS_IDX) or wr_s(CCR_IDX)) |=>
    rate_code == $past(wb_req.dat[1:0]))
    else $error("active rate not latest write");
  dma_gate_a: assert property (!wr0 |=> dma_irq_gate ==
    ($past(mode) == MODE_ALT || $past(st_reg.digital_output_control[DOC_DMA])))
    else $error("dma gate wrong for mode");
  // Read data was captured a cycle before the ack edge, so it stands now
  tape_read_a: assert property (rd_s(TDA_IDX) ##0 !st_reg.cfg[CFG_ENH2]
    |-> wb_dat_o[DAT_W-1:2] == '0)
    else $error("tape register upper bits not zero");
  wake_a: assert property (rd_s(DRS_IDX) |=> !power_down)
    else $error("status read did not end power-down");
  self_clear_a: assert property (wr_s(DRS_IDX) ##0 wb_req.dat[DRS_SRST]
    |=> fdc_reset ##[24:26] !st_reg.dsr[DRS_SRST])
    else $error("self-reset bit did not clear");
  hw_reset_a: assert property (@(posedge clk) disable iff (1'b0) srst |=>
    st_reg.digital_output_control == DOC_RESET && st_reg.dsr == DRS_RESET && !dma_irq_gate)
    else $error("hardware reset values wrong");

endmodule

// ---- sim/drive_cable_model.sv ----
`timescale 1ns/1ps
// Drive end of the cable: turns active-low lines into active-high state
module drive_cable_model
  import floppy_regs_pkg::*;
(
  // Cable lines
  input wire drive_pins_type drive_pins,
  // Drive state seen by the drives
  output wire logic [1:0] sel_on,
  output wire logic [1:0] mot_on
);
  // Active-low select and motor lines
  assign sel_on = ~{drive_pins.unit_select_out1_n, drive_pins.unit_select_out0_n};
  assign mot_on = ~{drive_pins.spindle_out1_n, drive_pins.spindle_out0_n};
endmodule

// ---- sim/floppy_ctl_output_rate_regs_tb_top.sv ----
`timescale 1ns/1ps
module floppy_ctl_output_rate_regs_tb_top
  import floppy_regs_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  wb_req_type req = '0;
  logic ack;
  logic [DAT_W-1:0] rdat;
  logic [DAT_W-1:0] q;
  drive_pins_type pins;
  logic frst;
  logic dgate;
  logic pdn;
  logic [1:0] rate;
  logic [2:0] shift;
  logic [1:0] sel_on;
  logic [1:0] mot_on;
  int n_errors = 0;
  int checks_done = 0;

  // Clock
  always #2 clk = ~clk;

  // Block and drive-side model
  floppy_ctl_output_rate_regs DUT (
    .clk(clk), .srst(srst), .wb_req(req), .wb_ack(ack), .wb_dat_o(rdat), .drive_pins(pins),
    .fdc_reset(frst), .dma_irq_gate(dgate), .power_down(pdn), .rate_code(rate), .write_shift_code(shift)
  );
  drive_cable_model cable (.drive_pins(pins), .sel_on(sel_on), .mot_on(mot_on));

  // Verdict and end of run
  task automatic conclude;
    $display("Counts: %0d checks, %0d mismatches", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [9:0] idx, input logic [15:0] d);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b1, we, 4'h3, {idx, 2'b00}, {16'h0000, d}};
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    q = rdat;
    req <= '0;
    if (n == 20) begin
      n_errors++;
      conclude();
    end
  endtask

  task automatic pause(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // Controller reset pulse length, bounded
  task automatic rst_len;
    int n;
    #1;
    chk(frst, 1'b1);
    for (n = 0; n < 40 && frst === 1'b1; n++) @(posedge clk);
    chk(n >= 16 && n <= 28, 1'b1);
  endtask

  task automatic t_reset;
    pause(1);
    chk(frst, 1'b1);
    chk({dgate, pdn, rate, shift}, 7'b0010000);
    chk({sel_on, mot_on}, 4'h0);
    wb(1'b0, DOC_IDX, 16'h0000);
    chk(q, 32'h0);
    $display("test reset done");
  endtask

  // Select and motor decode, both drive orders
  task automatic t_decode(input logic sw);
    logic [7:0] dv[4] = '{8'h1C, 8'h2D, 8'hC6, 8'h15};
    logic [5:0] ex[4] = '{6'b010101, 6'b011010, 6'b000000, 6'b000001};
    logic [5:0] e;
    wb(1'b1, CFG_IDX, {13'h0, sw, 2'b00});
    for (int i = 0; i < 4; i++) begin
      e = sw ? {ex[i][5:4], ex[i][2], ex[i][3], ex[i][0], ex[i][1]} : ex[i];
      wb(1'b1, DOC_IDX, {8'h00, dv[i]});
      pause(2);
      chk({frst, dgate, sel_on, mot_on}, e);
    end
    wb(1'b0, DOC_IDX, 16'h0000);
    chk(q, 32'h15);
    $display("test decode done");
  endtask

  task automatic t_dma;
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, CFG_IDX, 16'(m));
      wb(1'b1, DOC_IDX, 16'h0004);
      pause(2);
      chk(dgate, m == 2);
      wb(1'b1, DOC_IDX, 16'h000C);
      pause(2);
      chk(dgate, 1'b1);
    end
    wb(1'b1, CFG_IDX, 16'h0000);
    $display("test dma gate done");
  endtask

  task automatic t_rate;
    wb(1'b1, DRS_IDX, 16'h005D);
    pause(2);
    chk({pdn, rate, shift}, 6'b101111);
    wb(1'b0, DRS_IDX, 16'h0000);
    chk(q, 32'h0);
    pause(2);
    chk(pdn, 1'b0);
    wb(1'b1, CCR_IDX, 16'h0003);
    pause(2);
    chk(rate, 2'b11);
    wb(1'b1, DRS_IDX, 16'h0089);
    rst_len();
    chk({rate, shift}, 5'b01010);
    $display("test rate done");
  endtask

  // Back-to-back soft reset keeps output control, tape and rate registers
  task automatic t_soft;
    wb(1'b1, TDA_IDX, 16'h0002);
    wb(1'b1, DOC_IDX, 16'h0018);
    wb(1'b1, DOC_IDX, 16'h001C);
    rst_len();
    chk({rate, shift, sel_on}, 7'b0101001);
    wb(1'b0, DOC_IDX, 16'h0000);
    chk(q, 32'h1C);
    wb(1'b0, TDA_IDX, 16'h0000);
    chk(q, 32'h02);
    $display("test soft reset done");
  endtask

  task automatic t_tape;
    wb(1'b1, TDA_IDX, 16'h00FF);
    wb(1'b0, TDA_IDX, 16'h0000);
    chk(q, 32'h03);
    wb(1'b1, CFG_IDX, 16'hE428);
    for (int d = 0; d < 4; d++) begin
      wb(1'b1, DOC_IDX, 16'(4 + d));
      wb(1'b0, TDA_IDX, 16'h0000);
      chk(q, {26'h0, 2'(d), 4'b1011});
    end
    wb(1'b0, 10'h3F6, 16'h0000);
    chk(q, 32'h0);
    $display("test tape done");
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_decode(1'b0);
    t_decode(1'b1);
    t_dma();
    t_rate();
    t_soft();
    t_tape();
    conclude();
  end
endmodule
